/* File: shared/tcc_pkg.sv */
// constants and types for the timer channel control block
// Summary of operation
// RULE1: input capture sets the event flag on each selected pin edge
// RULE2: output compare and edge PWM set the flag on counter equal value
// RULE3: center PWM sets the flag on every match, counting up or down
// RULE4: interrupt request while flag and interrupt enable are set; reset clears enable
// RULE5: flag clears only by a read with flag set, then writing zero
// RULE6: an event between that read and write restarts the clear sequence
// RULE7: writing one to the flag does nothing; reset clears the flag
// RULE8: center select clear and upper mode bit set gives edge PWM
// RULE9: with both clear, lower mode bit picks capture (0) or compare (1)
// RULE10: edge/level field 00 releases the pin whatever the mode
// RULE11: capture edges: 01 rising, 10 falling, 11 either
// RULE12: compare action: 00 none, 01 toggle, 10 drive low, 11 drive high
// RULE13: edge PWM: 10 high-true cleared on compare, x1 low-true set
// RULE14: center select makes all center PWM; 10 clears on up match, x1 sets
// RULE15: entering capture may flag a spurious edge unless pin was stable
// RULE16: software should clear flags after reconfiguring, before enabling interrupts
// RULE17: center select makes the counter count up and down, else up only
// RULE18: an active capture edge copies the counter into the channel value
// RULE19: the interrupt request is a level held until flag or enable clears
package tcc_pkg;
    localparam int AW = 4;
    localparam int DW = 8;
    localparam int CW = 16;
    localparam int NSTS = 3;
    // register indices
    localparam logic [AW-1:0] A_CSC  = 4'h0;
    localparam logic [AW-1:0] A_MCTL = 4'h1;
    localparam logic [AW-1:0] A_VALH = 4'h2;
    localparam logic [AW-1:0] A_VALL = 4'h3;
    localparam logic [AW-1:0] A_MODH = 4'h4;
    localparam logic [AW-1:0] A_MODL = 4'h5;
    localparam logic [AW-1:0] A_CNTH = 4'h6;
    localparam logic [AW-1:0] A_CNTL = 4'h7;
    localparam logic [AW-1:0] A_STS  = 4'h8;
    localparam logic [AW-1:0] A_CLR  = 4'h9;
    localparam logic [AW-1:0] A_IEN  = 4'ha;
    // channel_status_control fields
    localparam int B_FLAG = 7;
    localparam int B_IE   = 6;
    localparam int B_MSHI = 5;
    localparam int B_MSLO = 4;
    localparam int B_ELSH = 3;
    localparam int B_ELSL = 2;
    // module control fields
    localparam int B_CAS = 5;
    localparam int B_RUN = 0;
    // event status bits
    localparam int S_CAP = 0;
    localparam int S_CMP = 1;
    localparam int S_OVF = 2;
    // edge/level encodings
    localparam logic [1:0] ELS_OFF  = 2'h0;
    localparam logic [1:0] ELS_RISE = 2'h1;
    localparam logic [1:0] ELS_FALL = 2'h2;
    localparam logic [1:0] ELS_BOTH = 2'h3;
    localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CW-1:0] CNT_ONE  = 16'h0001;
    localparam logic [CW-1:0] CNT_FULL = 16'hffff;
    localparam logic [DW-1:0] D_ZERO   = 8'h00;
    typedef enum logic [2:0] {MD_OFF, MD_IC, MD_OC, MD_EPWM, MD_CPWM} tcc_mode_e;
endpackage

/* File: design/tcc_channel.sv */
// one timer channel with its counter, mode decode, flag and register port
`timescale 1ns/100ps
module tcc_channel (
    input  wire logic                     ref_clk,
    input  wire logic                     arst_n,
    input  wire logic                     ce,
    input  wire logic [tcc_pkg::AW-1:0]   addr,
    input  wire logic [tcc_pkg::DW-1:0]   wdata,
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    output logic      [tcc_pkg::DW-1:0]   rdata,
    input  wire logic                     pin_in,
    output logic                          pin_out,
    output logic                          pin_oe,
    output logic                          irq
);
    import tcc_pkg::*;

    typedef struct packed {
        logic [CW-1:0]   cnt;
        logic            dir_up;
        logic [CW-1:0]   val;
        logic [CW-1:0]   modv;
        logic            flag;
        logic            ie;
        logic            mshi;
        logic            mslo;
        logic [1:0]      els;
        logic            cas;
        logic            run;
        logic            armed;
        logic            pin_q;
        logic [NSTS-1:0] sts;
        logic [NSTS-1:0] ien;
        logic            pout;
        logic            poe;
        logic            irq;
        logic [DW-1:0]   rdata;
    } tcc_state_s;

    tcc_state_s s_ff;
    tcc_state_s nxt_s;
    tcc_mode_e  mode;
    logic [CW-1:0] top;
    logic       match;
    logic       ovf;
    logic       rise;
    logic       fall;
    logic       cap_evt;
    logic       ch_evt;
    logic       csc_wr;
    logic       csc_rd;

    // mode decode from center select, mode bits and edge/level field
    always_comb begin
        if (s_ff.els == ELS_OFF) begin
            mode = MD_OFF;                         // [RULE10]
        end else if (s_ff.cas) begin
            mode = MD_CPWM;                        // [RULE14]
        end else if (s_ff.mshi) begin
            mode = MD_EPWM;                        // [RULE8]
        end else if (s_ff.mslo) begin
            mode = MD_OC;                          // [RULE9]
        end else begin
            mode = MD_IC;                          // [RULE9]
        end
    end

    // event detection; pin_q is sampled in every mode so a mode change sees no stale edge
    always_comb begin
        top     = (s_ff.modv == CNT_ZERO) ? CNT_FULL : s_ff.modv;
        match   = s_ff.run && (s_ff.cnt == s_ff.val);
        rise    = pin_in && !s_ff.pin_q;           // [RULE15]
        fall    = !pin_in && s_ff.pin_q;
        cap_evt = (mode == MD_IC) &&
                  ((s_ff.els[0] && rise) || (s_ff.els[1] && fall)); // [RULE11]
        ovf     = s_ff.run && (s_ff.cnt == top) && (!s_ff.cas || s_ff.dir_up);
        ch_evt  = cap_evt || (match && (mode != MD_IC)); // [RULE1] [RULE2] [RULE3]
        csc_wr  = wr_en && (addr == A_CSC);
        csc_rd  = rd_en && (addr == A_CSC);
    end

    // next state
    always_comb begin
        nxt_s       = s_ff;
        nxt_s.pin_q = pin_in;
        // counter: up only, or up and down with center select
        if (s_ff.run) begin
            if (!s_ff.cas) begin
                nxt_s.dir_up = 1'b1;
                nxt_s.cnt = (s_ff.cnt == top) ? CNT_ZERO : s_ff.cnt + CNT_ONE; // [RULE17]
            end else if (s_ff.dir_up) begin
                if (s_ff.cnt == top) begin
                    nxt_s.dir_up = 1'b0;           // [RULE17]
                    nxt_s.cnt    = s_ff.cnt - CNT_ONE;
                end else begin
                    nxt_s.cnt = s_ff.cnt + CNT_ONE;
                end
            end else if (s_ff.cnt == CNT_ZERO) begin
                nxt_s.dir_up = 1'b1;
                nxt_s.cnt    = CNT_ONE;
            end else begin
                nxt_s.cnt = s_ff.cnt - CNT_ONE;
            end
        end
        // register writes
        if (wr_en) begin
            if (addr == A_CSC) begin
                nxt_s.ie   = wdata[B_IE];
                nxt_s.mshi = wdata[B_MSHI];
                nxt_s.mslo = wdata[B_MSLO];
                nxt_s.els  = wdata[B_ELSH:B_ELSL];
            end else if (addr == A_MCTL) begin
                nxt_s.cas = wdata[B_CAS];
                nxt_s.run = wdata[B_RUN];
            end else if (addr == A_VALH) begin
                nxt_s.val[CW-1:DW] = wdata;
            end else if (addr == A_VALL) begin
                nxt_s.val[DW-1:0] = wdata;
            end else if (addr == A_MODH) begin
                nxt_s.modv[CW-1:DW] = wdata;
            end else if (addr == A_MODL) begin
                nxt_s.modv[DW-1:0] = wdata;
            end else if (addr == A_CNTH || addr == A_CNTL) begin
                nxt_s.cnt    = CNT_ZERO;           // any write restarts the counter
                nxt_s.dir_up = 1'b1;
            end else if (addr == A_CLR) begin
                nxt_s.sts = s_ff.sts & ~wdata[NSTS-1:0];
            end else if (addr == A_IEN) begin
                nxt_s.ien = wdata[NSTS-1:0];
            end
        end
        // capture copies the counter, winning over a value write
        if (cap_evt) begin
            nxt_s.val = s_ff.cnt;                  // [RULE18]
        end
        // flag clear sequence: read with flag set arms, zero write clears
        if (csc_rd && s_ff.flag) begin
            nxt_s.armed = 1'b1;                    // [RULE5]
        end
        if (csc_wr && !wdata[B_FLAG] && s_ff.armed) begin
            nxt_s.flag  = 1'b0;                    // [RULE5] [RULE7]
            nxt_s.armed = 1'b0;
        end
        if (ch_evt) begin
            nxt_s.flag  = 1'b1;                    // [RULE6]
            nxt_s.armed = 1'b0;                    // [RULE6]
        end
        // sticky event status, set beats clear
        nxt_s.sts = nxt_s.sts | {ovf, match && (mode != MD_IC), cap_evt};
        // pin action
        nxt_s.poe = (mode != MD_OFF) && (mode != MD_IC) &&
                    !((mode == MD_OC) && (s_ff.els == ELS_OFF)); // [RULE10]
        case (mode)
            MD_OC: begin
                if (match) begin
                    case (s_ff.els)                // [RULE12]
                        ELS_RISE: nxt_s.pout = !s_ff.pout;
                        ELS_FALL: nxt_s.pout = 1'b0;
                        ELS_BOTH: nxt_s.pout = 1'b1;
                        default:  nxt_s.pout = s_ff.pout;
                    endcase
                end
            end
            MD_EPWM: begin
                if (match) begin
                    nxt_s.pout = s_ff.els[0];      // [RULE13]
                end else if (s_ff.run && s_ff.cnt == CNT_ZERO) begin
                    nxt_s.pout = !s_ff.els[0];     // [RULE13]
                end
            end
            MD_CPWM: begin
                if (match) begin
                    nxt_s.pout = s_ff.dir_up ? s_ff.els[0] : !s_ff.els[0]; // [RULE14]
                end
            end
            default: begin
                nxt_s.pout = s_ff.pout;
            end
        endcase
        // level interrupt from flag and from enabled status bits
        nxt_s.irq = (nxt_s.flag && nxt_s.ie) || (|(nxt_s.sts & nxt_s.ien)); // [RULE4] [RULE19]
        // read data, present only in the cycle after the strobe
        nxt_s.rdata = D_ZERO;
        if (rd_en) begin
            if (addr == A_CSC) begin
                nxt_s.rdata = {s_ff.flag, s_ff.ie, s_ff.mshi, s_ff.mslo, s_ff.els, 2'b00};
            end else if (addr == A_MCTL) begin
                nxt_s.rdata[B_CAS] = s_ff.cas;
                nxt_s.rdata[B_RUN] = s_ff.run;
            end else if (addr == A_VALH) begin
                nxt_s.rdata = s_ff.val[CW-1:DW];
            end else if (addr == A_VALL) begin
                nxt_s.rdata = s_ff.val[DW-1:0];
            end else if (addr == A_MODH) begin
                nxt_s.rdata = s_ff.modv[CW-1:DW];
            end else if (addr == A_MODL) begin
                nxt_s.rdata = s_ff.modv[DW-1:0];
            end else if (addr == A_CNTH) begin
                nxt_s.rdata = s_ff.cnt[CW-1:DW];
            end else if (addr == A_CNTL) begin
                nxt_s.rdata = s_ff.cnt[DW-1:0];
            end else if (addr == A_STS) begin
                nxt_s.rdata[NSTS-1:0] = s_ff.sts;
            end else if (addr == A_IEN) begin
                nxt_s.rdata[NSTS-1:0] = s_ff.ien;
            end
        end
    end

    // state register; clock enable freezes everything
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff        <= '0;                     // [RULE4] [RULE7]
            s_ff.dir_up <= 1'b1;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign rdata   = s_ff.rdata;
    assign pin_out = s_ff.pout;
    assign pin_oe  = s_ff.poe;
    assign irq     = s_ff.irq;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence seq_arm;
        ce && csc_rd && s_ff.flag && !ch_evt;
    endsequence
    sequence seq_zero_wr;
        ce && csc_wr && !wdata[B_FLAG] && !ch_evt;
    endsequence

    // flag setting by each kind of event
    a_flag_ic_edge: assert property (ce && cap_evt // [RULE1]
        |=> s_ff.flag && s_ff.val == $past(s_ff.cnt))
        else $error("capture edge did not set flag and value");
    a_flag_cmp_match: assert property (ce && match && (mode == MD_OC || mode == MD_EPWM) // [RULE2]
        |=> s_ff.flag)
        else $error("compare match did not set flag");
    a_flag_cpwm_both: assert property (ce && match && mode == MD_CPWM |=> s_ff.flag) // [RULE3]
        else $error("center match did not set flag");
    a_ic_no_cmp: assert property (ce && mode == MD_IC && !cap_evt && !s_ff.flag // [RULE1]
        |=> !s_ff.flag)
        else $error("flag set in capture mode without an edge");
    a_flag_rise_cause: assert property ($rose(s_ff.flag) |-> $past(ch_evt)) // [RULE1]
        else $error("flag rose without a channel event");

    // interrupt request level and flag clear sequence
    a_irq_level_follows: assert property (ce |=> irq == ((s_ff.flag && s_ff.ie) || // [RULE4]
        (|(s_ff.sts & s_ff.ien))))
        else $error("irq disagrees with flag and enable");
    a_ie_write: assert property (ce && csc_wr // [RULE4]
        |=> s_ff.ie == $past(wdata[B_IE]))
        else $error("interrupt enable not taken from write");
    a_irq_holds: assert property (ce && irq && s_ff.flag && s_ff.ie && !wr_en // [RULE19]
        |=> irq)
        else $error("interrupt request dropped while flag and enable set");
    a_flag_clear_seq: assert property (seq_arm ##1 seq_zero_wr |=> !s_ff.flag) // [RULE5]
        else $error("read then zero write did not clear flag");
    a_flag_fall_cause: assert property ($fell(s_ff.flag) |-> $past(csc_wr && s_ff.armed)) // [RULE5]
        else $error("flag cleared without armed write");
    a_clear_restart: assert property (ce && ch_evt ##1 seq_zero_wr |=> s_ff.flag) // [RULE6]
        else $error("event before clearing write was lost");
    a_one_write_keeps: assert property (ce && csc_wr && wdata[B_FLAG] && !s_ff.flag // [RULE7]
        && !ch_evt |=> !s_ff.flag)
        else $error("writing one set the flag");
    a_write_one_hold: assert property (ce && csc_wr && wdata[B_FLAG] && s_ff.flag // [RULE7]
        |=> s_ff.flag)
        else $error("writing one cleared the flag");
    a_unarmed_keep: assert property (ce && csc_wr && s_ff.flag && !s_ff.armed // [RULE5]
        |=> s_ff.flag)
        else $error("flag cleared without a prior read");
    a_arm_on_read: assert property (ce && csc_rd && s_ff.flag && !ch_evt // [RULE5]
        |=> s_ff.armed)
        else $error("read with flag set did not arm the clear");
    a_event_disarm: assert property (ce && ch_evt |=> !s_ff.armed) // [RULE6]
        else $error("event left the clear sequence armed");

    // mode decode
    a_epwm_mode_sel: assert property (ce && !s_ff.cas && s_ff.mshi && s_ff.els != ELS_OFF // [RULE8]
        |-> mode == MD_EPWM)
        else $error("upper mode bit did not select edge pwm");
    a_oc_mode_sel: assert property (ce && !s_ff.cas && !s_ff.mshi && s_ff.mslo // [RULE9]
        && s_ff.els != ELS_OFF |-> mode == MD_OC)
        else $error("lower mode bit did not select compare");
    a_ic_mode_sel: assert property (ce && !s_ff.cas && !s_ff.mshi && !s_ff.mslo // [RULE9]
        && s_ff.els != ELS_OFF |-> mode == MD_IC)
        else $error("cleared mode bits did not select capture");
    a_cpwm_all: assert property (ce && s_ff.cas && s_ff.els != ELS_OFF // [RULE14]
        |-> mode == MD_CPWM)
        else $error("center select did not force center pwm");
    a_cas_no_ic: assert property (ce && s_ff.cas |-> !cap_evt) // [RULE14]
        else $error("capture event while center select set");

    // pin release and capture edge selection
    a_pin_release: assert property (ce && s_ff.els == ELS_OFF |=> !pin_oe) // [RULE10]
        else $error("pin driven with edge/level 00");
    a_off_no_cap: assert property (ce && mode == MD_OFF |-> !cap_evt) // [RULE10]
        else $error("capture event with pin released");
    a_cap_no_drive: assert property (ce && mode == MD_IC // [RULE1]
        |=> !pin_oe)
        else $error("pin driven in capture mode");
    a_cap_rise_sel: assert property (ce && mode == MD_IC && s_ff.els == ELS_RISE // [RULE11]
        |-> cap_evt == rise)
        else $error("rising edge select wrong");
    a_cap_fall_sel: assert property (ce && mode == MD_IC && s_ff.els == ELS_FALL // [RULE11]
        |-> cap_evt == fall)
        else $error("falling edge select wrong");
    a_cap_both_sel: assert property (ce && mode == MD_IC && s_ff.els == ELS_BOTH // [RULE11]
        |-> cap_evt == (rise || fall))
        else $error("either edge select wrong");
    a_ic_pin_stable: assert property (ce && mode == MD_IC && pin_in == s_ff.pin_q // [RULE15]
        |-> !cap_evt)
        else $error("capture event on a steady pin");

    // pin actions on compare
    a_oc_toggle: assert property (ce && mode == MD_OC && s_ff.els == ELS_RISE && match // [RULE12]
        |=> pin_out != $past(pin_out))
        else $error("toggle on compare missing");
    a_oc_drive_low: assert property (ce && mode == MD_OC && s_ff.els == ELS_FALL && match // [RULE12]
        |=> !pin_out)
        else $error("compare did not drive the pin low");
    a_oc_drive_high: assert property (ce && mode == MD_OC && s_ff.els == ELS_BOTH && match // [RULE12]
        |=> pin_out)
        else $error("compare did not drive the pin high");
    a_oc_sw_only: assert property (ce && s_ff.els == ELS_OFF // [RULE12]
        |=> pin_out == $past(pin_out))
        else $error("pin level moved with edge/level 00");
    a_epwm_match: assert property (ce && mode == MD_EPWM && match // [RULE13]
        |=> pin_out == $past(s_ff.els[0]))
        else $error("edge pwm level wrong on compare");
    a_epwm_period: assert property (ce && mode == MD_EPWM && s_ff.run && s_ff.cnt == CNT_ZERO // [RULE13]
        && !match |=> pin_out == !$past(s_ff.els[0]))
        else $error("edge pwm level wrong at period start");
    a_cpwm_up_match: assert property (ce && mode == MD_CPWM && match && s_ff.dir_up // [RULE14]
        |=> pin_out == $past(s_ff.els[0]))
        else $error("center pwm level wrong on up match");
    a_cpwm_dn_match: assert property (ce && mode == MD_CPWM && match && !s_ff.dir_up // [RULE14]
        |=> pin_out != $past(s_ff.els[0]))
        else $error("center pwm level wrong on down match");

    // counter direction and stepping
    a_cas_down: assert property (ce && s_ff.cas && s_ff.run && s_ff.dir_up && s_ff.cnt == top // [RULE17]
        && !wr_en |=> !s_ff.dir_up)
        else $error("center counter did not turn down");
    a_cas_turn_up: assert property (ce && s_ff.cas && s_ff.run && !s_ff.dir_up // [RULE17]
        && s_ff.cnt == CNT_ZERO && !wr_en |=> s_ff.dir_up)
        else $error("center counter did not turn up");
    a_up_wrap: assert property (ce && !s_ff.cas && s_ff.run && s_ff.cnt == top && !wr_en // [RULE17]
        |=> s_ff.cnt == CNT_ZERO)
        else $error("up counter did not wrap at top");
    a_up_step: assert property (ce && !s_ff.cas && s_ff.run && s_ff.cnt != top && !wr_en // [RULE17]
        |=> s_ff.cnt == $past(s_ff.cnt) + CNT_ONE)
        else $error("up counter did not step by one");
    a_dn_step: assert property (ce && s_ff.cas && s_ff.run && !s_ff.dir_up // [RULE17]
        && s_ff.cnt != CNT_ZERO && !wr_en |=> s_ff.cnt == $past(s_ff.cnt) - CNT_ONE)
        else $error("down counter did not step by one");
endmodule

/* File: tb/tcc_pin_model.sv */
// external signal source facing the timer channel pin
`timescale 1ns/100ps
module tcc_pin_model (
    input  wire logic ext_level,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_in
);
    // the wire follows the block while it drives, else the outside source
    assign pin_in = pin_oe ? pin_out : ext_level;
endmodule

/* File: tb/timer_channel_control_bench.sv */
// self-checking bench for the timer channel control block
`timescale 1ns/100ps
module timer_channel_control_bench;
    import tcc_pkg::*;
    logic          ref_clk;
    logic          arst_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr_en;
    logic          rd_en;
    logic [DW-1:0] rdata;
    logic          pin_in;
    logic          pin_out;
    logic          pin_oe;
    logic          irq;
    logic          ext_level;
    logic [DW-1:0] d;
    logic [DW-1:0] cfg_tb [7];
    logic [1:0]    exp_tb [7];
    int            n_fail;
    int            num_checks;

    tcc_channel u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .ce(1'b1), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
    tcc_pin_model u_pin (.ext_level(ext_level), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_in(pin_in));

    // free-running bus clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic final_report;
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(negedge ref_clk);
        v = rdata;
    endtask

    task automatic set_pin(input logic lvl);
        @(posedge ref_clk);
        ext_level <= lvl;
        repeat (3) @(posedge ref_clk);
    endtask

    // poll the channel flag with a bounded count
    task automatic wait_flag;
        for (int i = 0; i < 80; i++) begin
            rd(A_CSC, d);
            if (d[B_FLAG] === 1'b1) return;
        end
        n_fail++;
        $display("ERROR %0t: flag never set", $time);
        final_report();
    endtask

    // main sequence
    initial begin
        n_fail = 0;
        num_checks = 0;
        arst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ext_level = 1'b0;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        check({7'h00, irq}, 8'h00);
        rd(A_CSC, d);
        check(d, 8'h00);
        rd(4'hf, d);
        check(d, 8'h00);
        // capture edges for each edge select, pin held stable first
        for (int e = 1; e < 4; e++) begin
            set_pin(1'b0);
            wr(A_CSC, {4'h0, e[1:0], 2'b00});
            rd(A_CSC, d);
            wr(A_CSC, {4'h0, e[1:0], 2'b00});
            set_pin(1'b1);
            rd(A_CSC, d);
            check(d, {e[0], 3'h0, e[1:0], 2'b00});
            wr(A_CSC, {4'h0, e[1:0], 2'b00});
            set_pin(1'b0);
            rd(A_CSC, d);
            check(d, {e[1], 3'h0, e[1:0], 2'b00});
            wr(A_CSC, {4'h0, e[1:0], 2'b00});
        end
        // clear sequence: write one, event between read and write, write without read
        set_pin(1'b1);
        wr(A_CSC, 8'h8c);
        rd(A_CSC, d);
        check(d, 8'h8c);
        set_pin(1'b0);
        wr(A_CSC, 8'h0c);
        rd(A_CSC, d);
        check(d, 8'h8c);
        wr(A_CSC, 8'h0c);
        rd(A_CSC, d);
        check(d, 8'h0c);
        wr(A_CSC, 8'h4c);
        check({7'h00, irq}, 8'h00);
        set_pin(1'b1);
        check({7'h00, irq}, 8'h01);
        wr(A_CSC, 8'h4c);
        rd(A_CSC, d);
        check(d, 8'hcc);
        check({7'h00, irq}, 8'h01);
        wr(A_CSC, 8'h4c);
        @(negedge ref_clk);
        check({7'h00, irq}, 8'h00);
        set_pin(1'b0);
        wr(A_CSC, 8'h0c);
        @(negedge ref_clk);
        check({7'h00, irq}, 8'h00);
        rd(A_CSC, d);
        check(d, 8'h8c);
        // compare and edge pwm actions, expected {pin_oe, pin_out & pin_oe} after match
        cfg_tb = '{8'h1c, 8'h18, 8'h14, 8'h10, 8'h28, 8'h24, 8'h38};
        exp_tb = '{2'h3, 2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h2};
        wr(A_MODH, 8'h00);
        wr(A_MODL, 8'h20);
        wr(A_VALH, 8'h00);
        wr(A_VALL, 8'h10);
        wr(A_MCTL, 8'h01);
        for (int k = 0; k < 7; k++) begin
            wr(A_CSC, cfg_tb[k]);
            wr(A_CNTH, 8'h00);
            rd(A_CSC, d);
            wr(A_CSC, cfg_tb[k]);
            wait_flag();
            check({6'h00, pin_oe, pin_out & pin_oe}, {6'h00, exp_tb[k]});
        end
        // event status register: raise, mask, clear
        rd(A_STS, d);
        check(d & 8'h02, 8'h02);
        wr(A_IEN, 8'h02);
        @(negedge ref_clk);
        check({7'h00, irq}, 8'h01);
        wr(A_IEN, 8'h00);
        @(negedge ref_clk);
        check({7'h00, irq}, 8'h00);
        wr(A_MCTL, 8'h00);
        wr(A_CLR, 8'h02);
        rd(A_STS, d);
        check(d & 8'h02, 8'h00);
        // center pwm: flag on up and down matches, mode bits ignored
        wr(A_MCTL, 8'h21);
        wr(A_CSC, 8'h38);
        wr(A_CNTH, 8'h00);
        rd(A_CSC, d);
        wr(A_CSC, 8'h38);
        wait_flag();
        check({6'h00, pin_oe, pin_out}, 8'h02);
        wr(A_CSC, 8'h38);
        wait_flag();
        check({6'h00, pin_oe, pin_out}, 8'h03);
        final_report();
    end
endmodule
